// ### design/tccc_pkg.sv
// Constants, register map and state types for the timer capture/compare channels
package tccc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_TOP = 6'h2d;
    localparam logic [5:0] IDX_CNTH = 6'h2e;
    localparam logic [5:0] IDX_CNTL = 6'h2f;
    localparam logic [5:0] IDX_MODH = 6'h30;
    localparam logic [5:0] IDX_MODL = 6'h31;
    localparam logic [5:0] IDX_SC0 = 6'h32;
    localparam logic [5:0] IDX_CH0H = 6'h33;
    localparam logic [5:0] IDX_CH0L = 6'h34;
    localparam logic [5:0] IDX_SC1 = 6'h35;
    localparam logic [5:0] IDX_CH1H = 6'h36;
    localparam logic [5:0] IDX_CH1L = 6'h37;
    // Channel control/status bit positions
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int MSB_BIT = 5;
    localparam int MSA_BIT = 4;
    localparam int ELSB_BIT = 3;
    localparam int ELSA_BIT = 2;
    localparam int TOV_BIT = 1;
    localparam int MAX_BIT = 0;
    // Top control bit positions
    localparam int TOF_BIT = 7;
    localparam int TOIE_BIT = 6;
    localparam int HALT_BIT = 5;
    localparam int TRST_BIT = 4;
    // Reset values, external prescaler code and bus response codes
    localparam logic [15:0] MOD_RST = 16'hffff;
    localparam logic HALT_RST = 1'b1;
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin drive toward the port mux
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } tccc_pin_t;

    typedef struct packed {
        logic flag;
        logic arm;
        logic ie;
        logic msb;
        logic msa;
        logic elsb;
        logic elsa;
        logic tov;
        logic maxd;
        logic max_eff;
        logic [15:0] value;
        logic cap_lock;
        logic cmp_lock;
        logic level;
        logic s1;
        logic s2;
        logic prev;
    } tccc_chan_t;

    typedef struct packed {
        tccc_chan_t [1:0] ch;
        logic [15:0] cnt;
        logic [5:0] pre;
        logic [15:0] modv;
        logic mod_lock;
        logic overflow_flag;
        logic tof_arm;
        logic toie;
        logic halt;
        logic [2:0] ps;
        logic buf_sel;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } tccc_state_t;
endpackage : tccc_pkg

// ### design/tccc_timer_channels.sv
// Two-channel capture/compare/PWM timer section with AXI4-Lite registers
// Notes on behaviour
// - Counter at modulo sets overflow, restarts zero
// - Modulo high write mutes overflow until low
// - Reset sets both modulo bytes to ones
// - Flag on selected edge or compare match
// - Flag clears by read-set then zero write
// - Interrupt enable gates the channel request
// - Buffered select disables channel one except its value registers
// - Edge field 00 gives preset port level
// - Capture edge: rising, falling or both
// - Compare action: toggle, clear or set
// - Edge field 00 releases pin to port
// - Toggle on overflow only in compare
// - Overflow action beats simultaneous compare
// - Full duty force applies next period
// - Value registers hold capture or compare
// - Reading high byte blocks capture until low
// - Writing high byte blocks compare until low
// - Reset clears flag, enable, mode, edge, toggle
// - Counter reset clears counter, reads zero
// - Halt stops counter; set at reset
`timescale 1ns/1ps
module tccc_timer_channels
    import tccc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [1:0] channel_pin_in,
    output tccc_pin_t channel_pin,
    output logic [1:0] chan_irq,
    output logic overflow_irq
);
    tccc_state_t s;
    tccc_state_t next_s;
    logic tick;
    logic wrap;
    logic [6:0] pm7;
    logic [5:0] pmask;
    logic wr_go;
    logic [5:0] wr_idx;
    logic ar_hs;
    logic [5:0] rd_idx;
    logic rd_mapped;
    logic wr_mapped;
    logic [7:0] rd_byte;
    logic [1:0] en;
    logic [1:0] cap_mode;
    logic [1:0] cmp_mode;
    logic [1:0] cap_ev;
    logic [1:0] cmp_ev;
    logic [15:0] cmpv [1:0];

    // Prescaler tap; external clock source is not wired here, so 111 never ticks
    assign pm7 = (7'h01 << s.ps) - 7'h01;
    assign pmask = pm7[5:0];
    assign tick = !s.halt && (s.ps != PS_EXT) && ((s.pre & pmask) == pmask);
    assign wrap = tick && (s.cnt == s.modv);

    // Bus handshakes; one write and one read in flight at most
    assign awready = !s.aw_held;
    assign wready = !s.w_held;
    assign arready = !s.rvalid;
    assign ar_hs = arvalid && !s.rvalid;
    assign rd_idx = araddr[7:2];
    assign wr_go = s.aw_held && s.w_held && !s.bvalid;
    assign wr_idx = s.awaddr[7:2];
    assign rd_mapped = (rd_idx >= IDX_TOP) && (rd_idx <= IDX_CH1L);
    assign wr_mapped = (wr_idx >= IDX_TOP) && (wr_idx <= IDX_CH1L);
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = {24'h000000, s.rdata};
    assign rresp = s.rresp;

    // Channel one vanishes while channel zero runs buffered
    assign en[0] = 1'b1;
    assign en[1] = !s.ch[0].msb;
    // Buffered channel zero compares against the two value registers in turn
    assign cmpv[0] = (s.ch[0].msb && s.buf_sel) ? s.ch[1].value : s.ch[0].value;
    assign cmpv[1] = s.ch[1].value;

    // Per-channel mode decode and events
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign cap_mode[i] = en[i] && !s.ch[i].msb && !s.ch[i].msa && (s.ch[i].elsb || s.ch[i].elsa);
        assign cmp_mode[i] = en[i] && (s.ch[i].msb || s.ch[i].msa) && (s.ch[i].elsb || s.ch[i].elsa);
        // Edge detect sits behind the second sync stage only
        assign cap_ev[i] = cap_mode[i] && !s.ch[i].cap_lock
            && ((s.ch[i].elsa && s.ch[i].s2 && !s.ch[i].prev)
            || (s.ch[i].elsb && !s.ch[i].s2 && s.ch[i].prev));
        assign cmp_ev[i] = cmp_mode[i] && !s.ch[i].cmp_lock && tick && (s.cnt == cmpv[i]);
        assign chan_irq[i] = en[i] && s.ch[i].flag && s.ch[i].ie;
        assign channel_pin.out[i] = s.ch[i].level;
        assign channel_pin.oe[i] = cmp_mode[i];
    end
    assign overflow_irq = s.overflow_flag && s.toie;

    // Read data mux; control of a disabled channel one reads zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_idx)
            IDX_TOP: rd_byte = {s.overflow_flag, s.toie, s.halt, 1'b0, 1'b0, s.ps};
            IDX_CNTH: rd_byte = s.cnt[15:8];
            IDX_CNTL: rd_byte = s.cnt[7:0];
            IDX_MODH: rd_byte = s.modv[15:8];
            IDX_MODL: rd_byte = s.modv[7:0];
            IDX_SC0: rd_byte = {s.ch[0].flag, s.ch[0].ie, s.ch[0].msb, s.ch[0].msa,
                                s.ch[0].elsb, s.ch[0].elsa, s.ch[0].tov, s.ch[0].maxd};
            IDX_CH0H: rd_byte = s.ch[0].value[15:8];
            IDX_CH0L: rd_byte = s.ch[0].value[7:0];
            IDX_SC1: rd_byte = en[1] ? {s.ch[1].flag, s.ch[1].ie, 1'b0, s.ch[1].msa,
                                s.ch[1].elsb, s.ch[1].elsa, s.ch[1].tov, s.ch[1].maxd} : 8'h00;
            IDX_CH1H: rd_byte = s.ch[1].value[15:8];
            IDX_CH1L: rd_byte = s.ch[1].value[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    // Next-state: counter, bus reads, bus writes, then hardware events so a set beats a clear
    always_comb begin
        next_s = s;
        for (int i = 0; i < 2; i++) begin
            next_s.ch[i].s1 = channel_pin_in[i];
            next_s.ch[i].s2 = s.ch[i].s1;
            next_s.ch[i].prev = s.ch[i].s2;
        end
        // Counter and prescaler
        if (!s.halt) begin
            next_s.pre = s.pre + 6'h01;
        end
        if (wrap) begin
            next_s.cnt = 16'h0000;
            next_s.buf_sel = s.ch[0].msb ? !s.buf_sel : 1'b0;
        end else if (tick) begin
            next_s.cnt = s.cnt + 16'h0001;
        end
        if (!s.ch[0].msb) begin
            next_s.buf_sel = 1'b0;
        end
        // Bus response retirement
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (awvalid && !s.aw_held) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = awaddr;
        end
        if (wvalid && !s.w_held) begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata[7:0];
            next_s.wstrb0 = wstrb[0];
        end
        // Read and its side effects
        if (ar_hs) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_byte;
            next_s.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
            unique case (rd_idx)
                IDX_TOP: next_s.tof_arm = s.overflow_flag ? 1'b1 : s.tof_arm;
                IDX_SC0: next_s.ch[0].arm = s.ch[0].flag ? 1'b1 : s.ch[0].arm;
                IDX_SC1: next_s.ch[1].arm = (s.ch[1].flag && en[1]) ? 1'b1 : s.ch[1].arm;
                IDX_CH0H: next_s.ch[0].cap_lock = (!s.ch[0].msb && !s.ch[0].msa) ? 1'b1 : s.ch[0].cap_lock;
                IDX_CH0L: next_s.ch[0].cap_lock = 1'b0;
                IDX_CH1H: next_s.ch[1].cap_lock = !s.ch[1].msa ? 1'b1 : s.ch[1].cap_lock;
                IDX_CH1L: next_s.ch[1].cap_lock = 1'b0;
                default: next_s.rvalid = 1'b1;
            endcase
        end
        // Write, performed once both address and data are held
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (wr_go && s.wstrb0) begin
            unique case (wr_idx)
                IDX_TOP: begin
                    next_s.toie = s.wdata[TOIE_BIT];
                    next_s.halt = s.wdata[HALT_BIT];
                    next_s.ps = s.wdata[2:0];
                    if (!s.wdata[TOF_BIT] && s.tof_arm) begin
                        next_s.overflow_flag = 1'b0;
                        next_s.tof_arm = 1'b0;
                    end
                    // Self-clearing: only the write strobe acts, nothing is stored
                    if (s.wdata[TRST_BIT]) begin
                        next_s.cnt = 16'h0000;
                        next_s.pre = 6'h00;
                    end
                end
                IDX_MODH: begin
                    next_s.modv[15:8] = s.wdata;
                    next_s.mod_lock = 1'b1;
                end
                IDX_MODL: begin
                    next_s.modv[7:0] = s.wdata;
                    next_s.mod_lock = 1'b0;
                end
                IDX_SC0, IDX_SC1: begin
                    for (int i = 0; i < 2; i++) begin
                        if ((wr_idx == (i == 0 ? IDX_SC0 : IDX_SC1)) && en[i]) begin
                            next_s.ch[i].ie = s.wdata[IE_BIT];
                            next_s.ch[i].msb = (i == 0) ? s.wdata[MSB_BIT] : 1'b0;
                            next_s.ch[i].msa = s.wdata[MSA_BIT];
                            next_s.ch[i].elsb = s.wdata[ELSB_BIT];
                            next_s.ch[i].elsa = s.wdata[ELSA_BIT];
                            next_s.ch[i].tov = s.wdata[TOV_BIT];
                            next_s.ch[i].maxd = s.wdata[MAX_BIT];
                            // Writing a one leaves the flag alone
                            if (!s.wdata[FLAG_BIT] && s.ch[i].arm) begin
                                next_s.ch[i].flag = 1'b0;
                                next_s.ch[i].arm = 1'b0;
                            end
                        end
                    end
                end
                IDX_CH0H: begin
                    next_s.ch[0].value[15:8] = s.wdata;
                    next_s.ch[0].cmp_lock = (s.ch[0].msb || s.ch[0].msa) ? 1'b1 : s.ch[0].cmp_lock;
                end
                IDX_CH0L: begin
                    next_s.ch[0].value[7:0] = s.wdata;
                    next_s.ch[0].cmp_lock = 1'b0;
                end
                IDX_CH1H: begin
                    next_s.ch[1].value[15:8] = s.wdata;
                    next_s.ch[1].cmp_lock = s.ch[1].msa ? 1'b1 : s.ch[1].cmp_lock;
                end
                IDX_CH1L: begin
                    next_s.ch[1].value[7:0] = s.wdata;
                    next_s.ch[1].cmp_lock = 1'b0;
                end
                default: next_s.bvalid = 1'b1;
            endcase
        end
        // Overflow flag; a fresh overflow also disarms a pending clear
        if (wrap && !s.mod_lock) begin
            next_s.overflow_flag = 1'b1;
            next_s.tof_arm = 1'b0;
        end
        // Channel events and pin level
        for (int i = 0; i < 2; i++) begin
            if (cap_ev[i]) begin
                next_s.ch[i].value = s.cnt;
            end
            if (cap_ev[i] || cmp_ev[i]) begin
                next_s.ch[i].flag = 1'b1;
                next_s.ch[i].arm = 1'b0;
            end
            if (!s.ch[i].elsb && !s.ch[i].elsa) begin
                next_s.ch[i].level = !s.ch[i].msa;
            end else if (cmp_mode[i]) begin
                // Force is sampled only at period start so duty never tears mid-period
                if (wrap) begin
                    next_s.ch[i].max_eff = s.ch[i].maxd;
                end
                if (s.ch[i].tov && wrap) begin
                    next_s.ch[i].level = !s.ch[i].level;
                end else if (!s.ch[i].tov && s.ch[i].max_eff) begin
                    next_s.ch[i].level = !(s.ch[i].elsb && s.ch[i].elsa);
                end else if (cmp_ev[i]) begin
                    next_s.ch[i].level = s.ch[i].elsb ? s.ch[i].elsa : !s.ch[i].level;
                end
            end
        end
    end

    // State register; value registers clear too, though software may not rely on it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.modv <= MOD_RST;
            s.halt <= HALT_RST;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence flag0_read_armed;
        ar_hs && (rd_idx == IDX_SC0) && s.ch[0].flag && !cap_ev[0] && !cmp_ev[0];
    endsequence
    sequence flag0_zero_write;
        wr_go && s.wstrb0 && (wr_idx == IDX_SC0) && !s.wdata[FLAG_BIT] && !cap_ev[0] && !cmp_ev[0];
    endsequence

    wrap_to_zero_a: assert property (wrap && !(wr_go && wr_idx == IDX_TOP) |=> s.cnt == 16'h0000 && s.overflow_flag == !$past(s.mod_lock) || s.overflow_flag)
        else $error("counter did not wrap to zero");
    mod_inhibit_a: assert property ($rose(s.overflow_flag) |-> $past(!s.mod_lock))
        else $error("overflow flag set while modulo write pending");
    flag_clear_seq_a: assert property (flag0_read_armed ##1 flag0_zero_write |=> !s.ch[0].flag)
        else $error("flag not cleared by read then zero write");
    flag_fall_a: assert property ($fell(s.ch[0].flag) |-> $past(s.ch[0].arm))
        else $error("flag cleared without prior read");
    irq_gate_a: assert property ($rose(s.ch[1].flag) && s.ch[1].ie |-> chan_irq[1])
        else $error("enabled channel flag gave no request");
    chan1_off_a: assert property (s.ch[0].msb |-> !channel_pin.oe[1] && !chan_irq[1])
        else $error("channel one active in buffered mode");
    preset_level_a: assert property (!s.ch[0].elsb && !s.ch[0].elsa ##1 !s.ch[0].elsb && !s.ch[0].elsa
        |-> channel_pin.out[0] == !$past(s.ch[0].msa) && !channel_pin.oe[0])
        else $error("preset level or port release wrong");
    capture_block_a: assert property (s.ch[0].cap_lock && !(wr_go && wr_idx == IDX_CH0L) |=> $stable(s.ch[0].value))
        else $error("capture while high byte read pending");
    ovf_wins_a: assert property (cmp_mode[0] && s.ch[0].tov && wrap && cmp_ev[0]
        |=> channel_pin.out[0] != $past(channel_pin.out[0]))
        else $error("overflow toggle lost to compare");
    halt_hold_a: assert property (s.halt ##1 s.halt && !(wr_go && wr_idx == IDX_TOP) |-> $stable(s.cnt))
        else $error("counter moved while halted");
    trst_clear_a: assert property (wr_go && s.wstrb0 && wr_idx == IDX_TOP && s.wdata[TRST_BIT]
        |=> s.cnt == 16'h0000 && s.pre == 6'h00)
        else $error("counter reset did not clear");

    // Counter reset bit never reads back
    trst_reads_a: assert property (
        ar_hs && rd_idx == IDX_TOP
        |=> !rdata[TRST_BIT])
        else $error("counter reset bit read back");

    // Capture takes the count of its own cycle
    capture_value_a: assert property (
        cap_ev[0]
        |=> s.ch[0].value == $past(s.cnt))
        else $error("captured value wrong");

    // A match always leaves the flag set
    compare_flag_a: assert property (
        cmp_ev[0]
        |=> s.ch[0].flag)
        else $error("compare match gave no flag");

    // No match while the low byte is pending
    compare_block_a: assert property (
        s.ch[0].cmp_lock
        |-> !cmp_ev[0])
        else $error("compare while low byte pending");

    // Unlocked rising edge is captured
    rise_capture_a: assert property (
        cap_mode[0] && !s.ch[0].cap_lock
        && s.ch[0].elsa && s.ch[0].s2
        && !s.ch[0].prev
        |=> s.ch[0].flag)
        else $error("rising edge not captured");
endmodule : tccc_timer_channels

// ### testbench/tccc_pin_source.sv
// Model of the external signals that meet the two channel pins
`timescale 1ns/1ps
module tccc_pin_source
    import tccc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [1:0] level_cmd,
    input wire tccc_pin_t channel_pin,
    output logic [1:0] channel_pin_in
);
    logic [1:0] ext_level = 2'h0;

    // Source moves only after an edge and holds its level for whole cycles
    always @(posedge clk_sys) begin
        ext_level <= level_cmd;
    end

    // Wire level: the timer wins wherever it drives the pin
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            channel_pin_in[i] = channel_pin.oe[i] ? channel_pin.out[i] : ext_level[i];
        end
    end
endmodule : tccc_pin_source

// ### testbench/timer_channel_capture_compare_bench.sv
// Self-checking bench for the timer capture/compare channels
`timescale 1ns/1ps
module timer_channel_capture_compare_bench
    import tccc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic [3:0] wr_lanes = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, overflow_irq;
    logic [1:0] bresp, rresp, chan_irq, channel_pin_in;
    logic [1:0] level_cmd = 2'h0;
    logic [31:0] rdata;
    tccc_pin_t channel_pin;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 72;

    always #12.5 clk_sys = ~clk_sys;

    tccc_timer_channels tccc_timer_channels_inst (
        .clk_sys(clk_sys), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .channel_pin_in(channel_pin_in),
        .channel_pin(channel_pin), .chan_irq(chan_irq), .overflow_irq(overflow_irq)
    );

    tccc_pin_source tccc_pin_source_inst (
        .clk_sys(clk_sys), .level_cmd(level_cmd), .channel_pin(channel_pin), .channel_pin_in(channel_pin_in)
    );

    // Verdict and end of run, also reached by any exhausted wait
    task automatic complete_run();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic hang(input string what);
        n_mismatch++;
        $display("MISMATCH %s expected answer seen timeout", what);
        complete_run();
    endtask : hang

    // Write one byte; each channel is released at its own handshake edge
    task automatic reg_wr(input logic [5:0] idx, input logic [7:0] val);
        logic a, w, b;
        logic [31:0] rnd;
        int n;
        n = 0;
        b = 1'b0;
        rnd = $random(seed);
        @(posedge clk_sys);
        awaddr <= {idx, 2'h0};
        wdata <= {rnd[31:8], val};
        wstrb <= wr_lanes;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge clk_sys);
            a = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            @(posedge clk_sys);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
            n++;
            if (n > 50) hang("write response");
        end
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] idx, output logic [7:0] val, output logic [1:0] resp);
        logic a, r;
        int n;
        n = 0;
        r = 1'b0;
        @(posedge clk_sys);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(negedge clk_sys);
            a = arvalid & arready;
            r = rvalid;
            val = rdata[7:0];
            resp = rresp;
            @(posedge clk_sys);
            if (a) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
            n++;
            if (n > 50) hang("read data");
        end
    endtask : reg_rd

    // Counter halted and reset before any mode change
    task automatic set_mode(input logic [5:0] idx, input logic [7:0] val);
        reg_wr(IDX_TOP, 8'h30);
        reg_wr(idx, val);
    endtask : set_mode

    // Poll a status register until its flag shows, within a bounded count
    task automatic wait_flag(input logic [5:0] idx);
        logic [7:0] v;
        logic [1:0] rr;
        int n;
        n = 0;
        v = 8'h00;
        while (v[FLAG_BIT] !== 1'b1) begin
            reg_rd(idx, v, rr);
            n++;
            if (n > 200) hang("channel flag");
        end
    endtask : wait_flag

    initial begin
        logic [7:0] v, cfg, cv, prev;
        logic [1:0] rr;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, unmapped access and ignored lane
        reg_rd(IDX_MODH, v, rr);
        chk("modulo_high_byte", v, 8'hff);
        reg_rd(IDX_MODL, v, rr);
        chk("modulo_low_byte", v, 8'hff);
        reg_rd(IDX_SC0, v, rr);
        chk("chan0_control_status", v, 8'h00);
        reg_rd(IDX_SC1, v, rr);
        chk("chan1_control_status", v, 8'h00);
        reg_rd(IDX_TOP, v, rr);
        chk("timer_top_control", v, 8'h20);
        reg_rd(6'h3f, v, rr);
        chk("unmapped rresp", {6'h0, rr}, {6'h0, RESP_SLVERR});
        wr_lanes = 4'h0;
        reg_wr(IDX_MODL, 8'h00);
        wr_lanes = 4'h1;
        reg_rd(IDX_MODL, v, rr);
        chk("modulo_low_byte lane", v, 8'hff);
        reg_wr(IDX_TOP, 8'h30);
        reg_rd(IDX_TOP, v, rr);
        chk("counter reset readback", v, 8'h20);
        $display("test reset_and_bus done");
        // Modulo wrap and the high-byte mute, counter already reset
        reg_wr(IDX_MODH, 8'h00);
        reg_wr(IDX_MODL, 8'h40);
        reg_wr(IDX_TOP, 8'h00);
        repeat (100) @(posedge clk_sys);
        reg_rd(IDX_TOP, v, rr);
        chk("overflow_flag", {7'h0, v[TOF_BIT]}, 8'h01);
        reg_rd(IDX_CNTL, v, rr);
        chk("count below modulo", {7'h0, v <= 8'h40}, 8'h01);
        reg_wr(IDX_TOP, 8'h30);
        reg_rd(IDX_TOP, v, rr);
        reg_wr(IDX_TOP, 8'h30); // Halted, so no overflow can rearm the flag
        reg_wr(IDX_MODH, 8'h00);
        reg_wr(IDX_TOP, 8'h00);
        repeat (200) @(posedge clk_sys);
        reg_rd(IDX_TOP, v, rr);
        chk("overflow_flag muted", {7'h0, v[TOF_BIT]}, 8'h00);
        reg_wr(IDX_MODL, 8'h40);
        repeat (100) @(posedge clk_sys);
        reg_rd(IDX_TOP, v, rr);
        chk("overflow_flag unmuted", {7'h0, v[TOF_BIT]}, 8'h01);
        $display("test overflow done");
        // Capture on every edge code, flag clear and enable gating
        for (int code = 1; code < 4; code++) begin
            cfg = 8'(code << 2) | ((code == 1) ? 8'h40 : 8'h00);
            level_cmd <= 2'h0;
            set_mode(IDX_SC0, cfg);
            reg_wr(IDX_TOP, 8'h00);
            level_cmd <= 2'h1;
            repeat (8) @(posedge clk_sys);
            reg_rd(IDX_SC0, v, rr);
            chk("rise flag", {7'h0, v[FLAG_BIT]}, {7'h0, code[0]});
            @(negedge clk_sys);
            chk("chan_irq", {7'h0, chan_irq[0]}, {7'h0, code == 1});
            reg_rd(IDX_CH0H, cv, rr);
            reg_rd(IDX_CH0L, v, rr);
            chk("captured value", {7'h0, cv == 8'h00 && v <= 8'h40}, 8'h01);
            reg_wr(IDX_SC0, cfg);
            reg_wr(IDX_SC0, cfg | 8'h80);
            reg_rd(IDX_SC0, v, rr);
            chk("flag after clear", {7'h0, v[FLAG_BIT]}, 8'h00);
            level_cmd <= 2'h0;
            repeat (8) @(posedge clk_sys);
            reg_rd(IDX_SC0, v, rr);
            chk("fall flag", {7'h0, v[FLAG_BIT]}, {7'h0, code[1]});
        end
        // Reading the high byte holds off captures until the low byte
        reg_wr(IDX_SC0, 8'h0c);
        reg_rd(IDX_CH0H, v, rr);
        level_cmd <= 2'h1;
        repeat (8) @(posedge clk_sys);
        reg_rd(IDX_SC0, v, rr);
        chk("locked capture", {7'h0, v[FLAG_BIT]}, 8'h00);
        reg_rd(IDX_CH0L, v, rr);
        level_cmd <= 2'h0;
        repeat (8) @(posedge clk_sys);
        reg_rd(IDX_SC0, v, rr);
        chk("unlocked capture", {7'h0, v[FLAG_BIT]}, 8'h01);
        $display("test capture done");
        // Preset levels with the pin left to the port
        set_mode(IDX_SC0, 8'h10);
        repeat (3) @(negedge clk_sys);
        chk("preset oe", {7'h0, channel_pin.oe[0]}, 8'h00);
        chk("preset low", {7'h0, channel_pin.out[0]}, 8'h00);
        set_mode(IDX_SC0, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk("preset high", {7'h0, channel_pin.out[0]}, 8'h01);
        // Compare actions with random match values
        for (int act = 1; act < 4; act++) begin
            cv = 8'h01 + (8'($random(seed)) & 8'h3e);
            set_mode(IDX_SC0, 8'h10 | 8'(act << 2));
            reg_wr(IDX_CH0H, 8'h00);
            reg_wr(IDX_CH0L, cv);
            reg_rd(IDX_CH0L, v, rr);
            chk("compare value", v, cv);
            @(negedge clk_sys);
            prev = {7'h0, channel_pin.out[0]};
            chk("compare oe", {7'h0, channel_pin.oe[0]}, 8'h01);
            reg_wr(IDX_TOP, 8'h00);
            wait_flag(IDX_SC0);
            @(negedge clk_sys);
            chk("compare pin", {7'h0, channel_pin.out[0]}, (act == 1) ? {7'h0, ~prev[0]} : {7'h0, act == 3});
        end
        // Writing the high byte holds off matches until the low byte
        set_mode(IDX_SC0, 8'h14);
        reg_wr(IDX_CH0H, 8'h00);
        reg_wr(IDX_TOP, 8'h00);
        repeat (150) @(posedge clk_sys);
        reg_rd(IDX_SC0, v, rr);
        chk("locked compare", {7'h0, v[FLAG_BIT]}, 8'h00);
        reg_wr(IDX_CH0L, cv);
        wait_flag(IDX_SC0);
        $display("test compare done");
        // Buffered select takes channel one away
        set_mode(IDX_SC0, 8'h24);
        reg_wr(IDX_SC1, 8'h14);
        reg_rd(IDX_SC1, v, rr);
        chk("chan1 disabled", v, 8'h00);
        @(negedge clk_sys);
        chk("chan1 pin released", {7'h0, channel_pin.oe[1]}, 8'h00);
        $display("test buffered done");
        complete_run();
    end
endmodule : timer_channel_capture_compare_bench
